// ===== bench/prss_core_props.sv
// assertions on the ports of the power-up and reset sequencer
`timescale 1ns/1ps
module prss_core_props
    import prss_pkg::*;
#(
    parameter int INIT_CYC = PRSS_POWERUP_INIT_CYC, // init length, cycles
    parameter int ROW_W    = 13   // refresh row width
) (
    // clock, reset and the reset pin
    input wire logic             i_clk_sys,
    input wire logic             i_sys_rst,
    input wire logic             i_reset_n,
    // watched outputs
    input wire prss_cfg_t        o_cfg,
    input wire prss_stat_t       o_stat,
    input wire logic [ROW_W-1:0] o_refresh_row,
    input wire logic             o_refresh_pulse
);
    // init state lasts the budget less the pin latency
    localparam int ILO = INIT_CYC - PRSS_PIN_LAT_CYC - 1;
    localparam int IHI = INIT_CYC - PRSS_PIN_LAT_CYC + 1;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // pin low long enough to pass the synchroniser and the state flop
    sequence s_pin_low; !i_reset_n [*5]; endsequence
    sequence s_init_start; $rose(o_stat.init_busy); endsequence
    a_ready_in_time: assert property (
        s_init_start |-> ##[ILO:IHI] $rose(o_stat.ready))
        else $error("ready not at end of init");
    a_init_held_off: assert property (
        s_pin_low |-> !o_stat.init_busy && !o_stat.ready)
        else $error("init runs under reset pin");
    a_init_refresh: assert property (
        s_init_start |-> (o_stat.refresh_en && !o_stat.ready)
        ##[1:9] o_refresh_pulse)
        else $error("init without refresh");
    a_cfg_default: assert property (
        s_pin_low |-> o_cfg == {PRSS_CFG0_DEFAULT, PRSS_CFG1_DEFAULT})
        else $error("config not default");
    a_refresh_halt: assert property (
        s_pin_low |-> !o_stat.refresh_en && !o_refresh_pulse)
        else $error("refresh under reset pin");
    a_dpd_exit: assert property (
        s_pin_low |-> !o_stat.in_dpd)
        else $error("deep power-down kept");
    a_row_default: assert property (
        s_pin_low |-> o_refresh_row == PRSS_ROW_DEFAULT)
        else $error("row counter not default");
endmodule

// ===== bench/prss_core_test.sv
// self-checking bench for the power-up and reset sequencer
`timescale 1ns/1ps
module prss_core_test;
    import prss_pkg::*;
    localparam int INIT = 50;  // shortened init length
    logic i_clk_sys = 0, i_sys_rst = 1, i_dpd_enter = 0, i_cfg_we = 0;
    logic rst_go = 0, acc_go = 0, rude = 0, reset_n, cs_n, ck, err;
    prss_cfg_t i_cfg_wdata = '0, o_cfg, wd;
    prss_stat_t o_stat;
    logic [12:0] row;
    logic pulse;
    logic [16:0] rnd = 17'h1_5a71;  // 88689
    int failures = 0, cmp_count = 0, cycles = 0;
    prss_cfg_t exp_q[$];  // config expected at each ready rise
    prss_host host (.i_rst_go(rst_go), .i_acc_go(acc_go), .i_rude(rude),
        .i_ready(o_stat.ready), .o_reset_n(reset_n), .o_cs_n(cs_n),
        .o_ck(ck));
    prss_core #(.INIT_CYC(INIT)) dut (.i_clk_sys(i_clk_sys),
        .i_sys_rst(i_sys_rst), .i_reset_n(reset_n), .i_cs_n(cs_n),
        .i_ck(ck), .i_dpd_enter(i_dpd_enter), .i_cfg_we(i_cfg_we),
        .i_cfg_wdata(i_cfg_wdata), .o_cfg(o_cfg), .o_stat(o_stat),
        .o_refresh_row(row), .o_refresh_pulse(pulse), .o_select_err(err));
    always #5 i_clk_sys = ~i_clk_sys;
    function automatic logic [16:0] lfsr(input logic [16:0] x);
        return {x[15:0], x[16] ^ x[13]};
    endfunction
    task automatic chk(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            failures++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        while (o_stat.ready !== 1'b1 && n < 200) begin
            @(negedge i_clk_sys);
            n++;
        end
        chk(n < 200, "ready never came");
    endtask
    // reset pulse, with a config write issued in the cycle the reset pin drops
    task automatic pin_reset;
        exp_q.push_back({PRSS_CFG0_DEFAULT, PRSS_CFG1_DEFAULT});
        @(posedge i_clk_sys);
        rst_go <= 1'b1;
        i_cfg_we <= 1'b1;
        @(posedge i_clk_sys);
        rst_go <= 1'b0;
        i_cfg_we <= 1'b0;
        repeat (20) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
    endtask
    // watcher: each ready rise takes the oldest expected config
    always @(posedge i_clk_sys) begin
        if ($rose(o_stat.ready) && exp_q.size() > 0) begin
            chk(o_cfg === exp_q.pop_front(), "config at ready");
        end
    end
    // hang guard, far above the roughly 500 cycles of the run
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        exp_q.push_back({PRSS_CFG0_DEFAULT, PRSS_CFG1_DEFAULT});
        repeat (4) @(posedge i_clk_sys);
        i_sys_rst <= 1'b0;
        repeat (60) @(posedge i_clk_sys);
        @(negedge i_clk_sys);
        chk(o_stat === 4'h0, "init under reset pin");
        wait_ready();
        chk(row !== PRSS_ROW_DEFAULT, "no rows refreshed");
        $display("test power-up done");
        rnd = lfsr(rnd);
        wd = {rnd[15:0], ~rnd[15:0]};
        @(posedge i_clk_sys);
        i_cfg_wdata <= wd;
        i_cfg_we <= 1'b1;
        @(posedge i_clk_sys);
        i_cfg_we <= 1'b0;
        i_dpd_enter <= 1'b1;
        @(posedge i_clk_sys);
        i_dpd_enter <= 1'b0;
        @(negedge i_clk_sys);
        chk(o_cfg === wd, "config write lost");
        chk(o_stat.in_dpd === 1'b1, "no deep power-down");
        pin_reset();
        chk(o_stat.in_dpd === 1'b0, "still powered down");
        chk(row === PRSS_ROW_DEFAULT, "row not default");
        chk(o_stat.refresh_en === 1'b0, "refresh not halted");
        rude <= 1'b1;
        acc_go <= 1'b1;
        wait_ready();
        chk(err === 1'b1, "early select not flagged");
        $display("test reset with early select done");
        acc_go <= 1'b0;
        rude <= 1'b0;
        repeat (70) @(posedge i_clk_sys);
        pin_reset();
        chk(err === 1'b0, "flag not cleared by reset");
        wait_ready();
        chk(o_stat.refresh_en === 1'b1, "refresh not resumed");
        acc_go <= 1'b1;
        repeat (80) @(negedge i_clk_sys);
        chk(err === 1'b0, "legal select flagged");
        $display("test legal frame done");
        chk(exp_q.size() == 0, "config check missed");
        complete_run();
    end
endmodule
bind prss_core prss_core_props #(.INIT_CYC(INIT_CYC), .ROW_W(ROW_W)) u_props (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_reset_n(i_reset_n),
    .o_cfg(o_cfg), .o_stat(o_stat), .o_refresh_row(o_refresh_row),
    .o_refresh_pulse(o_refresh_pulse));

// ===== bench/prss_host.sv
// behavioural host controller: reset pin, select and bus clock
`timescale 1ns/1ps
module prss_host (
    // requests from the bench
    input  wire logic i_rst_go,  // rise: pulse the reset pin
    input  wire logic i_acc_go,  // rise: run one select frame
    input  wire logic i_rude,    // skip the wait for ready (fault case)
    input  wire logic i_ready,   // device ready
    // pins towards the device
    output logic      o_reset_n,
    output logic      o_cs_n,
    output logic      o_ck
);
    logic hold;  // set while no frame may start
    // power comes up with the reset pin held low
    initial begin
        hold = 1'b1;
        o_reset_n = 1'b0;
        o_cs_n = 1'b1;
        o_ck = 1'b0;
        #1000 o_reset_n = 1'b1;
        hold = 1'b0;
    end
    // pulse and reset-low-to-select wait kept generously, rise-to-select wait just 200 ns; no frame meanwhile
    always @(posedge i_rst_go) begin
        hold = 1'b1;
        o_reset_n = 1'b0;
        #400 o_reset_n = 1'b1;
        #200 hold = 1'b0;
    end
    // one short frame; clock stands still outside it
    always @(posedge i_acc_go) begin
        wait (!hold && (i_ready || i_rude));
        o_cs_n = 1'b0;
        #40;
        repeat (8) #62.5 o_ck = ~o_ck;
        #40 o_cs_n = 1'b1;
    end
endmodule

// ===== rtl/prss_core.sv
// power-up initialization, hardware reset and refresh control
`timescale 1ns/1ps
// What this block and its host must do
// [RULE_01] init completes within 150 us after power-up
// [RULE_02] host keeps select high during init
// [RULE_03] reset low at power-up delays init start
// [RULE_04] init interval runs refresh, then ready
// [RULE_05] reset restores default config, enters standby
// [RULE_06] self-refresh stops while reset low
// [RULE_07] reset low forces exit from deep power-down
// [RULE_08] reset returns refresh row counter to default
// [RULE_09] host treats array as lost after reset
// [RULE_10] host runs no transaction during reset
// [RULE_11] host waits 400 ns reset-low to select
// [RULE_12] reset pulse 200 ns, 200 ns to select
// [RULE_13] host select low limited to 4 or 1 us
// [RULE_14] host allows recovery, access, refresh gaps
// [RULE_15] host counts its own clocks for waits
module prss_core
    import prss_pkg::*;
#(
    parameter int INIT_CYC = PRSS_POWERUP_INIT_CYC, // init length, cycles
    parameter int ROW_W    = 13                     // refresh row width
) (
    // system clock and power-on reset (supply stable when released)
    input  wire logic              i_clk_sys,
    input  wire logic              i_sys_rst,
    // memory bus pins from the host
    input  wire logic              i_reset_n,
    input  wire logic              i_cs_n,
    input  wire logic              i_ck,
    // requests from the transaction core
    input  wire logic              i_dpd_enter,
    input  wire logic              i_cfg_we,
    input  wire prss_cfg_t         i_cfg_wdata,
    // state towards the transaction core
    output prss_cfg_t              o_cfg,
    output prss_stat_t             o_stat,
    output logic [ROW_W-1:0]       o_refresh_row,
    output logic                   o_refresh_pulse,
    output logic                   o_select_err
);
    // elaboration checks
    if (INIT_CYC <= PRSS_PIN_LAT_CYC) begin : g_chk_init
        $error("INIT_CYC must exceed the pin latency");
    end
    if (ROW_W < 1 || ROW_W > 13) begin : g_chk_row
        $error("ROW_W must be 1 to 13");
    end

    localparam int CNT_W = $clog2(INIT_CYC + 1);
    // the pin synchroniser and the state flop already spend part of the
    // init budget, so the counter stops that much early and ready still
    // lands inside the limit measured from the reset pin rise
    localparam logic [CNT_W-1:0] INIT_LAST =
        CNT_W'(INIT_CYC - 1 - PRSS_PIN_LAT_CYC);
    localparam logic [3:0] GAP_LAST = 4'(PRSS_REFRESH_GAP_CYC - 1);

    // synchronised pins
    logic rst_n_s;   // reset pin after two flops
    logic cs_n_s;    // select pin after two flops
    logic ck_s;      // bus clock after two flops

    // the reset pin is taken as asserted until two flops have seen it
    // high, so a power-up with the pin low never starts init early
    prss_sync #(.RESET_VAL(1'b0)) u_sync_rst (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_reset_n),
        .o_sync    (rst_n_s)
    );
    prss_sync #(.RESET_VAL(1'b1)) u_sync_cs (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_cs_n),
        .o_sync    (cs_n_s)
    );
    prss_sync #(.RESET_VAL(1'b0)) u_sync_ck (
        .i_clk_sys (i_clk_sys),
        .i_sys_rst (i_sys_rst),
        .i_async   (i_ck),
        .o_sync    (ck_s)
    );

    // state registers
    prss_state_t       state_r, state_nxt;     // operating state
    logic [CNT_W-1:0]  init_cnt_r, init_cnt_nxt; // init elapsed cycles
    logic [3:0]        gap_r, gap_nxt;         // refresh pacing
    logic [ROW_W-1:0]  row_r, row_nxt;         // self-refresh row
    prss_cfg_t         cfg_r, cfg_nxt;         // configuration
    logic              rpulse_r, rpulse_nxt;   // one row refreshed
    logic              serr_r, serr_nxt;       // select during init
    prss_stat_t        stat_r, stat_nxt;       // registered status
    logic              ck_d_r;                 // last bus clock sample
    logic              ck_rise;                // bus clock edge seen
    logic              refresh_on;             // self-refresh running

    // bus clock idles low and ck_d_r resets low, so no false edge
    // follows a system reset
    assign ck_rise = ck_s & ~ck_d_r;

    // sequencing: reset, initialization, ready, deep power-down
    always_comb begin
        state_nxt    = state_r;
        init_cnt_nxt = init_cnt_r;
        cfg_nxt      = cfg_r;
        case (state_r)
            PRSS_ST_RESET: begin
                // wait for the reset pin to go high before timing
                init_cnt_nxt = '0;
                if (rst_n_s) begin
                    state_nxt = PRSS_ST_INIT; // [RULE_03]
                end
            end
            PRSS_ST_INIT: begin
                // count the init interval; ends within the limit
                if (init_cnt_r == INIT_LAST) begin
                    state_nxt = PRSS_ST_READY; // [RULE_01] [RULE_04]
                end else begin
                    init_cnt_nxt = init_cnt_r + CNT_W'(1);
                end
            end
            PRSS_ST_READY: begin
                // normal operation: config writes, deep power-down
                if (i_cfg_we) begin
                    cfg_nxt = i_cfg_wdata;
                end
                if (i_dpd_enter && cs_n_s) begin
                    state_nxt = PRSS_ST_DPD;
                end
            end
            PRSS_ST_DPD: begin
                // only the reset pin leaves this state here
                state_nxt = PRSS_ST_DPD;
            end
            default: begin
                state_nxt = PRSS_ST_RESET;
            end
        endcase
        // reset pin low overrides everything, including deep power-down
        if (!rst_n_s) begin
            state_nxt    = PRSS_ST_RESET; // [RULE_05] [RULE_07]
            init_cnt_nxt = '0;
            cfg_nxt.cfg0 = PRSS_CFG0_DEFAULT; // [RULE_05]
            cfg_nxt.cfg1 = PRSS_CFG1_DEFAULT;
        end
    end

    // self-refresh: halted in reset and deep power-down
    always_comb begin
        refresh_on = (state_r == PRSS_ST_INIT) ||
                     (state_r == PRSS_ST_READY); // [RULE_06]
        gap_nxt    = gap_r;
        row_nxt    = row_r;
        rpulse_nxt = 1'b0;
        if (!refresh_on) begin
            // in reset, row counter back to its start so refresh restarts there
            gap_nxt = '0;
            if (state_r == PRSS_ST_RESET) begin
                row_nxt = PRSS_ROW_DEFAULT[ROW_W-1:0]; // [RULE_08]
            end
        end else if (gap_r == GAP_LAST) begin
            // init uses the same row walk to prime the array
            gap_nxt    = '0;
            row_nxt    = row_r + ROW_W'(1); // [RULE_04]
            rpulse_nxt = 1'b1;
        end else begin
            gap_nxt = gap_r + 4'(1);
        end
    end

    // status and select-during-init flag
    // status decodes the next state so it moves with state_r; the cost
    // is a longer path through the sequencing logic
    always_comb begin
        stat_nxt.ready      = (state_nxt == PRSS_ST_READY);
        stat_nxt.refresh_en = (state_nxt == PRSS_ST_INIT) ||
                              (state_nxt == PRSS_ST_READY);
        stat_nxt.init_busy  = (state_nxt == PRSS_ST_INIT);
        stat_nxt.in_dpd     = (state_nxt == PRSS_ST_DPD);
        // a select with a bus clock rise in any state but ready is a host fault; sticky till reset
        serr_nxt = serr_r;
        if (!rst_n_s) begin
            serr_nxt = 1'b0;
        end else if (!cs_n_s && ck_rise &&
                     state_r != PRSS_ST_READY) begin
            serr_nxt = 1'b1; // [RULE_02] [RULE_10]
        end
    end

    // registers
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            state_r    <= PRSS_ST_RESET;
            init_cnt_r <= '0;
            gap_r      <= '0;
            row_r      <= PRSS_ROW_DEFAULT[ROW_W-1:0];
            cfg_r      <= {PRSS_CFG0_DEFAULT, PRSS_CFG1_DEFAULT};
            rpulse_r   <= 1'b0;
            serr_r     <= 1'b0;
            stat_r     <= '0;
            ck_d_r     <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            init_cnt_r <= init_cnt_nxt;
            gap_r      <= gap_nxt;
            row_r      <= row_nxt;
            cfg_r      <= cfg_nxt;
            rpulse_r   <= rpulse_nxt;
            serr_r     <= serr_nxt;
            stat_r     <= stat_nxt;
            ck_d_r     <= ck_s;
        end
    end

    // outputs straight from flops
    assign o_cfg           = cfg_r;
    assign o_stat          = stat_r;
    assign o_refresh_row   = row_r;
    assign o_refresh_pulse = rpulse_r;
    assign o_select_err    = serr_r;
endmodule

// ===== rtl/prss_pkg.sv
// constants and carrier types for the power-up and reset sequencer
package prss_pkg;

    // clock rate of i_clk_sys in kHz (100 MHz)
    localparam int PRSS_CLK_KHZ = 100_000;

    // power-up initialization time, in microseconds
    localparam int PRSS_POWERUP_INIT_TIME_US = 150;
    // longest time rounds down: cycles = us * kHz / 1000
    localparam int PRSS_POWERUP_INIT_CYC =
        (PRSS_POWERUP_INIT_TIME_US * PRSS_CLK_KHZ) / 1000;
    // cycles from a reset pin rise to the init state: two sync flops
    // and the state flop; the init count gives these back
    localparam int PRSS_PIN_LAT_CYC = 3;

    // refresh sequencing: one row refresh every so many cycles
    localparam int PRSS_REFRESH_GAP_CYC = 8;
    // default starting row of the self-refresh counter
    localparam logic [12:0] PRSS_ROW_DEFAULT = 13'h0000;

    // default value of configuration register 0 (arbitrary plain value)
    localparam logic [15:0] PRSS_CFG0_DEFAULT = 16'h8f1f;
    // default value of configuration register 1 (arbitrary plain value)
    localparam logic [15:0] PRSS_CFG1_DEFAULT = 16'h0002;

    // device operating states
    typedef enum logic [1:0] {
        PRSS_ST_RESET,
        PRSS_ST_INIT,
        PRSS_ST_READY,
        PRSS_ST_DPD
    } prss_state_t;

    // configuration held by the device
    typedef struct packed {
        logic [15:0] cfg0;
        logic [15:0] cfg1;
    } prss_cfg_t;

    // status carried to the core
    typedef struct packed {
        logic        ready;
        logic        refresh_en;
        logic        init_busy;
        logic        in_dpd;
    } prss_stat_t;

endpackage

// ===== rtl/prss_sync.sv
// two-flop synchroniser for one level from outside the clock domain
`timescale 1ns/1ps
module prss_sync
    import prss_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1  // value held during system reset
) (
    // clock and reset
    input  wire logic i_clk_sys,
    input  wire logic i_sys_rst,
    // asynchronous level in, synchronised level out
    input  wire logic i_async,
    output logic      o_sync
);
    logic meta_r;  // first stage, read only by the second
    logic meta_nxt;
    logic sync_r;  // second stage
    logic sync_nxt;

    // next values: plain shift
    always_comb begin
        meta_nxt = i_async;
        sync_nxt = meta_r;
    end

    // registers
    always_ff @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            meta_r <= RESET_VAL;
            sync_r <= RESET_VAL;
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign o_sync = sync_r;
endmodule
